// ---- design/seek_pkg.sv ----
package seek_pkg;
	localparam int CYL_W = 8;
	localparam int NUM_DRIVES = 4;
	localparam int DRV_W = 2;
	localparam int RECAL_MAX_STEPS = 79;
	localparam int STEP_CNT_W = 7;
	localparam int CLK_MHZ = 40;
	// step pulse width on the drive pin
	localparam int STEP_PULSE_US = 1;
	localparam int STEP_PULSE_CYC = STEP_PULSE_US * CLK_MHZ;
	// one unit of step interval setting, in microseconds
	localparam int STEP_UNIT_US = 500;
	localparam int STEP_UNIT_CYC = STEP_UNIT_US * CLK_MHZ;
	localparam int SRT_W = 4;
	localparam int TMR_W = 24;
	localparam int INDEX_LIMIT = 2;
	localparam logic [1:0] TC_NORMAL = 2'h0;
	localparam logic [1:0] TC_ABNORMAL = 2'h1;
	localparam logic [1:0] TC_POLL = 2'h3;
	localparam int ST0_TC_HI = 7;
	localparam int ST0_TC_LO = 6;
	localparam int ST0_DONE = 5;
	localparam int ST0_TRK0 = 4;
	localparam int ST0_SIDE = 2;
	localparam logic DIR_IN = 1'b1;
	localparam logic DIR_OUT = 1'b0;
	typedef enum logic [2:0]
	{
		CMD_NONE,
		CMD_SEEK,
		CMD_RSEEK,
		CMD_RECAL,
		CMD_READ_ID,
		CMD_SENSE_INT,
		CMD_SENSE_DRV
	} cmd_t;
endpackage : seek_pkg

// ---- design/step_if.sv ----
`timescale 1ns/1ps
interface step_if;
	import seek_pkg::*;
	logic                fire;
	logic [SRT_W-1:0]    rate;
	logic                first;
	logic                done;
	logic                pulse;
	modport ctl (output fire, output rate, output first, input done,
		input pulse);
	modport gen (input fire, input rate, input first, output done,
		output pulse);
endinterface : step_if

// ---- design/step_gen.sv ----
`timescale 1ns/1ps
module step_gen
	import seek_pkg::*;
#(
	parameter int UNIT_CYC = STEP_UNIT_CYC
)
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// control side
	step_if.gen       st
);
	logic [TMR_W-1:0] tmr_r;
	logic             busy_r;
	logic             pulse_r;
	logic [TMR_W-1:0] span;

	// first gap is half length; a zero setting means sixteen units
	always_comb
	begin
		span = TMR_W'((st.rate == '0 ? 16 : int'(st.rate)) * UNIT_CYC);
		if (st.first)
			span = span >> 1;
		if (span < TMR_W'(STEP_PULSE_CYC + 1))
			span = TMR_W'(STEP_PULSE_CYC + 1);
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			tmr_r   <= '0;
			busy_r  <= 1'b0;
			pulse_r <= 1'b0;
		end
		else if (st.fire && !busy_r)
		begin
			tmr_r   <= span;
			busy_r  <= 1'b1;
			pulse_r <= 1'b1;
		end
		else if (busy_r)
		begin
			tmr_r <= tmr_r - TMR_W'(1);
			if (tmr_r == TMR_W'(span - TMR_W'(STEP_PULSE_CYC)))
				pulse_r <= 1'b0;
			if (tmr_r == TMR_W'(1))
				busy_r <= 1'b0;
		end
	end

	assign st.done  = busy_r && tmr_r == TMR_W'(1);
	assign st.pulse = pulse_r;
endmodule : step_gen

// ---- design/head_seek_control.sv ----
`timescale 1ns/1ps
// Functional notes
// - only Read ID, Recalibrate, Seek and Relative Seek raise the interrupt on completion.
// - Read ID captures cylinder, head, sector, size of first good ID field.
// - no ID mark by second index: code 01, missing-mark flag, end.
// - Recalibrate clears present cylinder, direction 0, steps while track zero low.
// - track zero high during Recalibrate sets positioning done, terminates.
// - still low after 79 steps: done plus track-zero-not-found, terminate.
// - busy only in command phase for Seek and Recalibrate, four drives overlap (here one positioning command at a time; others are refused until it ends).
// - Seek compares cylinders; lower steps in with 1, higher out with 0.
// - steps spaced by step interval setting, recompare each step, done on equal.
// - side-select bit in status zero is 0 after positioning commands.
// - leaving powerdown clears present cylinder and stored interrupt status.
// - interrupt on result phase entry, positioning end, non-DMA byte need.
// - Sense Interrupt Status clears interrupt, returns status zero.
// - cause codes: poll 0/11, normal 1/00, abnormal 1/01.
// - without Sense Interrupt Status the drive stays marked busy.
// - Sense Drive Status goes straight to result with status register 3.
// - step interval spaces pulses; first gap may be shorter.
// - Relative Seek outward past track zero sets track-zero-not-found.
module head_seek_control
	import seek_pkg::*;
#(
	parameter int UNIT_CYC = STEP_UNIT_CYC
)
(
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// command port
	input  wire logic             cmd_valid,
	input  wire cmd_t             cmd_code,
	input  wire logic [DRV_W-1:0] cmd_drive,
	input  wire logic [CYL_W-1:0] cmd_target,
	input  wire logic             cmd_rel_dir,
	input  wire logic [SRT_W-1:0] step_interval_setting,
	output logic                  cmd_busy,
	// result port
	output logic                  res_valid,
	output logic [7:0]            res_status_zero,
	output logic [CYL_W-1:0]      res_cylinder,
	output logic [7:0]            res_status_three,
	output logic                  res_no_id_mark_flag,
	// read id capture
	input  wire logic             id_valid,
	input  wire logic [7:0]       id_cyl,
	input  wire logic [7:0]       id_head,
	input  wire logic [7:0]       id_sector,
	input  wire logic [7:0]       id_size,
	output logic [31:0]           id_chrn,
	// other interrupt sources, powerdown exit and drive status three
	input  wire logic             xfer_result_entry,
	input  wire logic             nondma_byte_req,
	input  wire logic             poll_event,
	input  wire logic             powerdown_exit,
	input  wire logic [7:0]       drive_status_three,
	// drive pins, drive busy flags and interrupt line
	input  wire logic             track_zero_in,
	input  wire logic             index_pulse_in,
	output logic                  step_out,
	output logic                  dir_out,
	output logic [NUM_DRIVES-1:0] drive_busy,
	output logic                  irq
);
	typedef enum logic [2:0] {S_IDLE, S_DIR, S_STEP, S_WAIT, S_RID} st_t;
	st_t                          state_r;
	logic [CYL_W-1:0]             pcn_r [NUM_DRIVES];
	logic [CYL_W-1:0]             target_cylinder_r;
	logic [DRV_W-1:0]             drv_r;
	cmd_t                         kind_r;
	logic [STEP_CNT_W-1:0]        nsteps_r;
	logic [1:0]                   idx_r;
	logic                         idx_d_r;
	logic                         first_r;
	logic [7:0]                   pend_st0_r [NUM_DRIVES];
	logic [NUM_DRIVES-1:0]        pend_r;
	logic                         fin;
	logic [7:0]                   fin_st0;
	logic [CYL_W-1:0]             present_cylinder;
	logic                         need_step;
	step_if                       st ();

	step_gen #(.UNIT_CYC(UNIT_CYC)) u_step
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.st      (st)
	);

	assign present_cylinder = pcn_r[drv_r];
	assign st.rate  = step_interval_setting;
	assign st.first = first_r;
	assign st.fire  = state_r == S_STEP;
	assign step_out = st.pulse;

	// busy while a positioning command is taken (S_DIR), for all of Read ID, and for any command offered outside idle
	assign cmd_busy = state_r == S_RID || (cmd_valid && state_r != S_IDLE)
		|| state_r == S_DIR;

	always_comb
	begin
		need_step = 1'b0;
		if (kind_r == CMD_RECAL)
			need_step = !track_zero_in;
		else if (kind_r == CMD_SEEK)
			need_step = present_cylinder != target_cylinder_r;
		else if (kind_r == CMD_RSEEK)
			need_step = target_cylinder_r != '0;
	end

	// completion and status zero of positioning commands
	always_comb
	begin
		fin = 1'b0;
		fin_st0 = 8'h00;
		fin_st0[1:0] = drv_r;
		fin_st0[ST0_SIDE] = 1'b0;
		fin_st0[ST0_DONE] = 1'b1;
		if (state_r == S_WAIT && st.done)
			fin = !need_step || (kind_r == CMD_RECAL
				&& nsteps_r == STEP_CNT_W'(RECAL_MAX_STEPS));
		if (state_r == S_DIR && !need_step)
			fin = 1'b1;
		// outward relative seek stops before wrapping past cylinder zero
		if ((state_r == S_DIR || (state_r == S_WAIT && st.done))
			&& kind_r == CMD_RSEEK && !dir_out
			&& present_cylinder == '0 && need_step)
			fin = 1'b1;
		if (kind_r == CMD_RECAL && need_step)
		begin
			fin_st0[ST0_TRK0] = 1'b1;
			fin_st0[ST0_TC_HI:ST0_TC_LO] = TC_ABNORMAL;
		end
		if (kind_r == CMD_RSEEK && need_step)
		begin
			fin_st0[ST0_TRK0] = 1'b1;
			fin_st0[ST0_TC_HI:ST0_TC_LO] = TC_ABNORMAL;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_r <= S_IDLE;
			kind_r <= CMD_NONE;
			drv_r <= '0;
			target_cylinder_r <= '0;
			nsteps_r <= '0;
			first_r <= 1'b0;
			dir_out <= DIR_OUT;
		end
		else
		begin
			case (state_r)
				S_IDLE:
				begin
					if (cmd_valid && (cmd_code == CMD_SEEK
						|| cmd_code == CMD_RSEEK || cmd_code == CMD_RECAL))
					begin
						kind_r <= cmd_code;
						drv_r <= cmd_drive;
						target_cylinder_r <= cmd_target;
						nsteps_r <= '0;
						first_r <= 1'b1;
						state_r <= S_DIR;
						if (cmd_code == CMD_RECAL)
							dir_out <= DIR_OUT;
						else if (cmd_code == CMD_RSEEK)
							dir_out <= cmd_rel_dir;
						else
							dir_out <= pcn_r[cmd_drive] < cmd_target ?
								DIR_IN : DIR_OUT;
					end
					else if (cmd_valid && cmd_code == CMD_READ_ID)
					begin
						kind_r <= cmd_code;
						state_r <= S_RID;
					end
				end
				// direction settled two cycles before the first pulse
				S_DIR:
					state_r <= fin ? S_IDLE : S_STEP;
				S_STEP:
				begin
					state_r <= S_WAIT;
					// count down at the pulse so the recompare sees it
					if (kind_r == CMD_RSEEK)
						target_cylinder_r <= target_cylinder_r - CYL_W'(1);
				end
				S_WAIT:
				begin
					if (st.done)
					begin
						first_r <= 1'b0;
						state_r <= fin ? S_IDLE : S_STEP;
					end
				end
				S_RID:
				begin
					if (id_valid || idx_r == 2'(INDEX_LIMIT))
						state_r <= S_IDLE;
				end
				default:
					state_r <= S_IDLE;
			endcase
			if (state_r == S_STEP)
				nsteps_r <= nsteps_r + STEP_CNT_W'(1);
		end
	end

	// present cylinder per drive
	always_ff @(posedge clk_sys)
	begin
		if (rst || powerdown_exit)
		begin
			for (int i = 0; i < NUM_DRIVES; i++)
				pcn_r[i] <= '0;
		end
		else if (state_r == S_DIR && kind_r == CMD_RECAL)
			pcn_r[drv_r] <= '0;
		else if (state_r == S_STEP && kind_r != CMD_RECAL)
			pcn_r[drv_r] <= dir_out == DIR_IN ? present_cylinder + CYL_W'(1)
				: present_cylinder - CYL_W'(1);
	end

	// read id: index count and capture
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			idx_r <= '0;
			idx_d_r <= 1'b1;
			id_chrn <= '0;
			res_no_id_mark_flag <= 1'b0;
		end
		else
		begin
			idx_d_r <= index_pulse_in;
			if (state_r != S_RID)
				idx_r <= '0;
			else if (idx_d_r && !index_pulse_in)
				idx_r <= idx_r + 2'(1);
			if (state_r == S_RID && id_valid)
			begin
				id_chrn <= {id_cyl, id_head, id_sector, id_size};
				res_no_id_mark_flag <= 1'b0;
			end
			else if (state_r == S_RID && idx_r == 2'(INDEX_LIMIT))
				res_no_id_mark_flag <= 1'b1;
		end
	end

	// pending interrupt status per drive; a new end wins over a sense
	always_ff @(posedge clk_sys)
	begin
		if (rst || powerdown_exit)
		begin
			pend_r <= '0;
			for (int i = 0; i < NUM_DRIVES; i++)
				pend_st0_r[i] <= 8'h00;
		end
		else
		begin
			if (cmd_valid && state_r == S_IDLE && cmd_code == CMD_SENSE_INT
				&& pend_r != '0)
				pend_r[res_status_zero_drv()] <= 1'b0;
			if (fin)
			begin
				pend_r[drv_r] <= 1'b1;
				pend_st0_r[drv_r] <= fin_st0;
			end
		end
	end

	function automatic logic [DRV_W-1:0] res_status_zero_drv();
		logic [DRV_W-1:0] d;
		d = '0;
		for (int i = NUM_DRIVES - 1; i >= 0; i--)
			if (pend_r[i])
				d = DRV_W'(i);
		return d;
	endfunction : res_status_zero_drv

	assign drive_busy = pend_r;

	// results
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			res_valid <= 1'b0;
			res_status_zero <= 8'h00;
			res_cylinder <= '0;
			res_status_three <= 8'h00;
		end
		else
		begin
			res_valid <= 1'b0;
			if (cmd_valid && state_r == S_IDLE && cmd_code == CMD_SENSE_INT)
			begin
				res_valid <= 1'b1;
				if (pend_r != '0)
				begin
					res_status_zero <= pend_st0_r[res_status_zero_drv()];
					res_cylinder <= pcn_r[res_status_zero_drv()];
				end
				else
					res_status_zero <= {TC_POLL, 6'h00};
			end
			else if (cmd_valid && state_r == S_IDLE
				&& cmd_code == CMD_SENSE_DRV)
			begin
				res_valid <= 1'b1;
				res_status_three <= drive_status_three;
			end
			else if (state_r == S_RID && (id_valid
				|| idx_r == 2'(INDEX_LIMIT)))
			begin
				res_valid <= 1'b1;
				res_status_zero <= {id_valid ? TC_NORMAL : TC_ABNORMAL,
					6'h00};
			end
		end
	end

	// interrupt line
	always_ff @(posedge clk_sys)
	begin
		if (rst || powerdown_exit)
			irq <= 1'b0;
		else if (fin || xfer_result_entry || nondma_byte_req || poll_event
			|| (state_r == S_RID && (id_valid
			|| idx_r == 2'(INDEX_LIMIT))))
			irq <= 1'b1;
		else if (cmd_valid && state_r == S_IDLE && cmd_code == CMD_SENSE_INT)
			irq <= 1'b0;
	end

	property recal_dir_p;
		@(posedge clk_sys) disable iff (rst)
		(kind_r == CMD_RECAL && state_r == S_STEP) |-> dir_out == DIR_OUT;
	endproperty
	recal_dir_a: assert property (recal_dir_p)
		else $error("recalibrate direction not out");

	sequence step_issue_s;
		state_r == S_STEP;
	endsequence
	dir_stable_a: assert property (@(posedge clk_sys) disable iff (rst)
		step_issue_s |=> $stable(dir_out))
		else $error("direction moved during step");

	recal_limit_a: assert property (@(posedge clk_sys) disable iff (rst)
		kind_r == CMD_RECAL |-> nsteps_r <= STEP_CNT_W'(RECAL_MAX_STEPS))
		else $error("too many steps");

	side_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
		fin |-> fin_st0[ST0_SIDE] == 1'b0 && fin_st0[ST0_DONE])
		else $error("bad status zero on finish");

	fin_irq_a: assert property (@(posedge clk_sys) disable iff (rst)
		fin && !powerdown_exit |=> irq && pend_r[$past(drv_r)])
		else $error("finish did not raise interrupt");

	sense_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
		cmd_valid && state_r == S_IDLE && cmd_code == CMD_SENSE_INT
		&& !fin && !xfer_result_entry && !nondma_byte_req && !poll_event
		|=> !irq && res_valid)
		else $error("sense did not clear interrupt");

	seek_equal_a: assert property (@(posedge clk_sys) disable iff (rst)
		fin && kind_r == CMD_SEEK |-> present_cylinder == target_cylinder_r)
		else $error("seek ended off target");

	pd_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
		powerdown_exit |=> pend_r == '0 && pcn_r[0] == '0)
		else $error("powerdown exit did not clear");

	drv_stat_a: assert property (@(posedge clk_sys) disable iff (rst)
		cmd_valid && state_r == S_IDLE && cmd_code == CMD_SENSE_DRV
		|=> res_valid && res_status_three == $past(drive_status_three))
		else $error("drive status not returned");
endmodule : head_seek_control

// ---- bench/drive_model.sv ----
`timescale 1ns/1ps
module drive_model
#(
	parameter int START_CYL = 5,
	parameter int IDX_PER   = 300
)
(
	// clock
	input  wire logic clk_sys,
	// drive pins
	input  wire logic step_out,
	input  wire logic dir_out,
	output logic      track_zero_in,
	output logic      index_pulse_in,
	// bench control and observation
	input  wire logic park_far,
	output int        n_steps,
	output logic      step_dir
);
	int   pos_r  = START_CYL;
	int   tick_r = 0;
	logic step_r = 1'b0;
	int   cnt_r  = 0;
	logic sdir_r = 1'b0;
	assign n_steps  = cnt_r;
	assign step_dir = sdir_r;
	// head moves one track per step edge and stops at track zero
	always @(posedge clk_sys)
	begin
		step_r <= step_out;
		tick_r <= (tick_r + 1) % IDX_PER;
		if (park_far)
			pos_r <= 120;
		else if (step_out && !step_r)
		begin
			cnt_r    <= cnt_r + 1;
			sdir_r   <= dir_out;
			pos_r    <= dir_out ? pos_r + 1 : (pos_r > 0 ? pos_r - 1 : 0);
		end
	end
	assign track_zero_in  = (pos_r == 0);
	// index line idles high, low for four cycles each turn
	assign index_pulse_in = (tick_r > 3);
endmodule : drive_model

// ---- bench/head_seek_control_tb.sv ----
`timescale 1ns/1ps
module head_seek_control_tb;
	import seek_pkg::*;
	logic             clk_sys = 1'b0;
	logic             rst = 1'b1;
	logic             cmd_valid = 1'b0;
	cmd_t             cmd_code = CMD_NONE;
	logic [DRV_W-1:0] cmd_drive = 2'h0;
	logic [CYL_W-1:0] cmd_target = 8'h00;
	logic             cmd_rel_dir = 1'b0;
	logic [SRT_W-1:0] step_interval_setting = 4'h0;
	logic             id_valid = 1'b0;
	logic [31:0]      id_in = 32'h0;
	logic             xfer_result_entry = 1'b0;
	logic             nondma_byte_req = 1'b0;
	logic             poll_event = 1'b0;
	logic             powerdown_exit = 1'b0;
	logic [7:0]       drive_status_three = 8'h00;
	logic             park_far = 1'b0;
	logic             cmd_busy, res_valid, res_no_id_mark_flag;
	logic             step_out, dir_out, irq, track_zero_in;
	logic             index_pulse_in, step_dir;
	logic [7:0]       res_status_zero, res_cylinder, res_status_three;
	logic [31:0]      id_chrn;
	logic [3:0]       drive_busy;
	int               n_steps, s0, mismatches = 0, n_compared = 0;
	logic [7:0]       tgt [3] = '{8'h0A, 8'h03, 8'h03};
	int               nst [3] = '{10, 7, 0};

	head_seek_control #(.UNIT_CYC(4)) head_seek_control_i (.clk_sys,
		.rst, .cmd_valid, .cmd_code, .cmd_drive, .cmd_target, .cmd_rel_dir,
		.step_interval_setting, .cmd_busy, .res_valid, .res_status_zero,
		.res_cylinder, .res_status_three, .res_no_id_mark_flag, .id_valid,
		.id_cyl(id_in[31:24]), .id_head(id_in[23:16]),
		.id_sector(id_in[15:8]), .id_size(id_in[7:0]), .id_chrn,
		.xfer_result_entry, .nondma_byte_req, .poll_event, .powerdown_exit,
		.drive_status_three, .track_zero_in, .index_pulse_in, .step_out,
		.dir_out, .drive_busy, .irq);
	drive_model drive_model_i (.clk_sys, .step_out, .dir_out,
		.track_zero_in, .index_pulse_in, .park_far, .n_steps, .step_dir);

	initial
	begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask : tick

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic issue(input cmd_t c, input logic [1:0] d,
		input logic [7:0] t, input logic rd);
		cmd_code    = c;
		cmd_drive   = d;
		cmd_target  = t;
		cmd_rel_dir = rd;
		cmd_valid   = 1'b1;
		tick(1);
		cmd_valid   = 1'b0;
	endtask : issue

	task automatic wait_res(input int lim);
		int n;
		n = 0;
		while (res_valid !== 1'b1 && n < lim)
		begin
			tick(1);
			n++;
		end
		check(res_valid, 1'b1);
	endtask : wait_res

	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 8000)
		begin
			tick(1);
			n++;
		end
		check(irq, 1'b1);
	endtask : wait_irq

	// sense interrupt, then the line must have dropped
	task automatic sense(input logic [7:0] st0);
		issue(CMD_SENSE_INT, 2'h0, 8'h00, 1'b0);
		wait_res(4);
		check(res_status_zero, st0);
		tick(1);
		check(irq, 1'b0);
	endtask : sense

	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	initial
	begin
		repeat (60000) @(posedge clk_sys);
		mismatches++;
		finish_test();
	end

	initial
	begin
		tick(4);
		rst = 1'b0;
		s0 = n_steps;
		issue(CMD_RECAL, 2'h0, 8'h00, 1'b0);
		tick(3);
		check(cmd_busy, 1'b0);
		wait_irq();
		check(n_steps - s0, 5);
		check(step_dir, DIR_OUT);
		check(drive_busy[0], 1'b1);
		sense(8'h20);
		check(drive_busy, 4'h0);
		$display("test recalibrate done");
		for (int k = 0; k < 3; k++)
		begin
			s0 = n_steps;
			issue(CMD_SEEK, 2'h2, tgt[k], 1'b0);
			wait_irq();
			check(n_steps - s0, nst[k]);
			if (nst[k] > 0)
				check(step_dir, k == 0 ? DIR_IN : DIR_OUT);
			tick(20);
			check(drive_busy[2], 1'b1);
			sense(8'h22);
			check(res_cylinder, tgt[k]);
		end
		$display("test seek done");
		sense(8'hC0);
		poll_event = 1'b1;
		tick(1);
		poll_event = 1'b0;
		wait_irq();
		sense(8'hC0);
		$display("test poll done");
		issue(CMD_READ_ID, 2'h0, 8'h00, 1'b0);
		tick(5);
		id_in    = 32'h03010702;
		id_valid = 1'b1;
		tick(1);
		id_valid = 1'b0;
		wait_res(4);
		check(id_chrn, 32'h03010702);
		check(res_no_id_mark_flag, 1'b0);
		wait_irq();
		issue(CMD_SENSE_INT, 2'h0, 8'h00, 1'b0);
		tick(3);
		check(irq, 1'b0);
		issue(CMD_READ_ID, 2'h0, 8'h00, 1'b0);
		wait_res(700);
		check(res_status_zero[7:6], TC_ABNORMAL);
		check(res_no_id_mark_flag, 1'b1);
		issue(CMD_SENSE_INT, 2'h0, 8'h00, 1'b0);
		tick(3);
		$display("test read id done");
		drive_status_three = 8'h5A;
		issue(CMD_SENSE_DRV, 2'h1, 8'h00, 1'b0);
		wait_res(4);
		check(res_status_three, 8'h5A);
		tick(5);
		check(irq, 1'b0);
		$display("test drive status done");
		park_far = 1'b1;
		tick(1);
		park_far = 1'b0;
		s0 = n_steps;
		issue(CMD_RECAL, 2'h0, 8'h00, 1'b0);
		wait_irq();
		check(n_steps - s0, RECAL_MAX_STEPS);
		sense(8'h70);
		issue(CMD_RSEEK, 2'h0, 8'h01, 1'b0);
		wait_irq();
		sense(8'h70);
		s0 = n_steps;
		issue(CMD_RSEEK, 2'h0, 8'h03, 1'b1);
		wait_irq();
		check(n_steps - s0, 3);
		sense(8'h20);
		check(res_cylinder, 8'h03);
		$display("test track zero limits done");
		for (int k = 0; k < 2; k++)
		begin
			xfer_result_entry = (k == 0);
			nondma_byte_req   = (k == 1);
			tick(1);
			xfer_result_entry = 1'b0;
			nondma_byte_req   = 1'b0;
			wait_irq();
			issue(CMD_SENSE_INT, 2'h0, 8'h00, 1'b0);
			tick(3);
			check(irq, 1'b0);
		end
		$display("test irq sources done");
		issue(CMD_SEEK, 2'h1, 8'h04, 1'b0);
		wait_irq();
		powerdown_exit = 1'b1;
		tick(1);
		powerdown_exit = 1'b0;
		tick(2);
		check(irq, 1'b0);
		check(drive_busy, 4'h0);
		sense(8'hC0);
		s0 = n_steps;
		issue(CMD_SEEK, 2'h1, 8'h00, 1'b0);
		wait_irq();
		check(n_steps - s0, 0);
		sense(8'h21);
		$display("test powerdown done");
		finish_test();
	end
endmodule : head_seek_control_tb
